// [verilog/ctn_pkg.sv]
// package: constants, types and register map of the trap and nmi vectoring unit
package ctn_pkg;
    // vector table
    localparam int          VEC_TABLE_ENTRIES = 256;
    localparam logic [19:0] VEC_TABLE_END     = 20'h003ff;
    localparam logic [7:0]  USER_TYPE_MIN     = 8'h20;
    // type numbers
    localparam logic [7:0]  T_DIVIDE  = 8'h00;
    localparam logic [7:0]  T_STEP    = 8'h01;
    localparam logic [7:0]  T_NMI     = 8'h02;
    localparam logic [7:0]  T_BREAK   = 8'h03;
    localparam logic [7:0]  T_OVFL    = 8'h04;
    localparam logic [7:0]  T_BOUND   = 8'h05;
    localparam logic [7:0]  T_UNDEF   = 8'h06;
    localparam logic [7:0]  T_ESC     = 8'h07;
    localparam logic [7:0]  T_NUMERIC = 8'h10;
    // opcodes decoded here
    localparam logic [7:0]  OP_BREAK  = 8'hcc;
    localparam logic [7:0]  OP_TRAPNN = 8'hcd;
    localparam logic [7:0]  OP_OVFL   = 8'hce;
    localparam logic [7:0]  OP_BOUND  = 8'h62;
    localparam logic [4:0]  OP_ESC_HI = 5'h1b;   // d8..df
    // flag word bit positions
    localparam int          FLAG_TF = 8;
    localparam int          FLAG_IF = 9;
    localparam int          FLAG_OF = 11;
    // timing
    localparam int          CLK_NS          = 50;
    localparam int          NMI_RESP_CLKS   = 42;
    localparam int          NMI_BOOT_CLKS   = 10;
    localparam logic [19:0] RESET_START_ADDR = 20'hffff0;
    // register map and reset values
    localparam logic [7:0]  REG_CTRL   = 8'h00;
    localparam logic [7:0]  REG_STATUS = 8'h04;
    localparam logic [7:0]  REG_NEST   = 8'h08;
    localparam logic [1:0]  CTRL_RST   = 2'h0;
    localparam int          CTRL_ESC_EN = 0;
    localparam int          CTRL_BUS8   = 1;
    localparam int          STAT_LATE   = 9;

    // what the core reports at an instruction boundary
    typedef struct packed {
        logic        boundary;
        logic [7:0]  opcode;
        logic [7:0]  imm;
        logic        div_fault;
        logic        undef_op;
        logic        seg_prefix;
        logic [15:0] start_ip;
        logic [15:0] op_ip;
        logic [15:0] next_ip;
        logic [15:0] cs;
        logic [15:0] ss;
        logic [15:0] sp;
        logic [15:0] flags;
        logic [15:0] bound_idx;
        logic [15:0] bound_lo;
        logic [15:0] bound_hi;
    } ctn_core_t;

    // what the unit hands back to the core
    typedef struct packed {
        logic        hold;
        logic        done;
        logic [15:0] cs;
        logic [15:0] ip;
        logic [15:0] flags;
        logic [15:0] sp;
    } ctn_entry_t;

    // stack and vector memory request
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [19:0] addr;
        logic [15:0] wdata;
    } ctn_mem_req_t;

    typedef enum logic [2:0] {
        S_IDLE, S_PUSH_F, S_PUSH_CS, S_PUSH_IP, S_RD_IP, S_RD_CS, S_DONE
    } ctn_state_t;
endpackage

// [verilog/ctn_trap_unit.sv]
// trap, exception and nmi vectoring unit with apb control registers
//
// Design decisions made here: register access over APB and the register offsets.
module ctn_trap_unit
    import ctn_pkg::*;
(
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // apb slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output logic              pready,
    output logic [31:0]       prdata,
    output logic              pslverr,
    // core side
    input  wire ctn_core_t    core_in,
    output ctn_entry_t        core_out,
    // memory side
    output ctn_mem_req_t      mem_req,
    input  wire logic         mem_ack,
    input  wire logic [15:0]  mem_rdata,
    // pins
    input  wire logic         nmi_pin,
    input  wire logic         coproc_err_pin
);
    ctn_state_t   state_r;
    logic [1:0]   ctrl_r;
    logic [7:0]   type_r, last_type_r, nest_r;
    logic [15:0]  ctx_cs_r, ctx_ip_r, ctx_flags_r, ctx_ss_r, ctx_sp_r;
    logic [15:0]  sw_ip_r, new_ip_r;
    logic         tf_prev_r, ss_pend_r, nmi_pend_r, sw_pend_r, err_pend_r;
    logic [7:0]   sw_type_r;
    logic         nmi_s1_r, nmi_s2_r, nmi_s3_r, nmi_lat_r;
    logic         err_s1_r, err_s2_r;
    logic [3:0]   boot_cnt_r;
    logic [5:0]   lat_cnt_r;
    logic         late_r;
    logic         sw_hit, sw_fault, nmi_edge, boot_win, start, bnd;
    logic         evt_at_bnd;
    logic [7:0]   sw_type;
    logic [15:0]  fault_ip;
    logic [19:0]  stack_addr;
    logic         acc, wr_ok;

    // pin synchronisers, nmi edge detect and latch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nmi_s1_r <= 1'b0;
            nmi_s2_r <= 1'b0;
            nmi_s3_r <= 1'b0;
            err_s1_r <= 1'b0;
            err_s2_r <= 1'b0;
        end else begin
            nmi_s1_r <= nmi_pin;
            nmi_s2_r <= nmi_s1_r;
            nmi_s3_r <= nmi_s2_r;
            err_s1_r <= coproc_err_pin;
            err_s2_r <= err_s1_r;
        end
    end
    assign nmi_edge = nmi_s2_r & ~nmi_s3_r;

    // boot window counted from the release of reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_cnt_r <= 4'(NMI_BOOT_CLKS);
        end else if (boot_cnt_r != 4'h0) begin
            boot_cnt_r <= boot_cnt_r - 4'h1;
        end
    end
    assign boot_win = (boot_cnt_r != 4'h0);
    assign bnd      = core_in.boundary & (state_r == S_IDLE);

    // decode of instruction traps at the boundary
    always_comb begin
        sw_hit   = 1'b1;
        sw_fault = 1'b1;
        sw_type  = T_DIVIDE;
        fault_ip = core_in.start_ip;
        if (core_in.div_fault) begin
            sw_type = T_DIVIDE;
        end else if (core_in.undef_op) begin
            sw_type = T_UNDEF;
        end else if (core_in.opcode[7:3] == OP_ESC_HI && (ctrl_r[CTRL_BUS8] || ctrl_r[CTRL_ESC_EN])) begin
            sw_type  = T_ESC;
            fault_ip = core_in.seg_prefix ? core_in.start_ip : core_in.op_ip;
        end else if (core_in.opcode == OP_BOUND &&
                     ($signed(core_in.bound_idx) < $signed(core_in.bound_lo) ||
                      $signed(core_in.bound_idx) > $signed(core_in.bound_hi))) begin
            sw_type = T_BOUND;
        end else begin
            sw_fault = 1'b0;
            if (core_in.opcode == OP_BREAK) begin
                sw_type = T_BREAK;
            end else if (core_in.opcode == OP_TRAPNN) begin
                sw_type = core_in.imm;
            end else if (core_in.opcode == OP_OVFL && core_in.flags[FLAG_OF]) begin
                sw_type = T_OVFL;
            end else begin
                sw_hit = 1'b0;
            end
        end
    end

    // nmi latch, cleared when moved to pending; a new edge wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nmi_lat_r <= 1'b0;
        end else if (nmi_edge) begin
            nmi_lat_r <= 1'b1;
        end else if (bnd || (boot_win && state_r == S_IDLE)) begin
            nmi_lat_r <= 1'b0;
        end
    end

    // pending events captured at boundaries; the latched nmi also moves in while idle in the boot window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tf_prev_r  <= 1'b0;
            ss_pend_r  <= 1'b0;
            nmi_pend_r <= 1'b0;
            sw_pend_r  <= 1'b0;
            err_pend_r <= 1'b0;
            sw_type_r  <= 8'h00;
            sw_ip_r    <= 16'h0000;
        end else begin
            if (bnd) begin
                tf_prev_r <= core_in.flags[FLAG_TF];
                if (tf_prev_r && core_in.flags[FLAG_TF]) begin
                    ss_pend_r <= 1'b1;
                end
                if (sw_hit) begin
                    sw_pend_r <= 1'b1;
                    sw_type_r <= sw_type;
                    sw_ip_r   <= sw_fault ? fault_ip : core_in.next_ip;
                end
                if (err_s2_r && !ctrl_r[CTRL_BUS8]) begin
                    err_pend_r <= 1'b1;
                end
            end
            if (start) begin
                if (ss_pend_r) begin
                    ss_pend_r <= 1'b0;
                end else if (nmi_pend_r) begin
                    nmi_pend_r <= 1'b0;
                end else if (sw_pend_r) begin
                    sw_pend_r <= 1'b0;
                end else begin
                    err_pend_r <= 1'b0;
                end
            end
            // latched nmi moves in after the clear, so a new request is never lost
            if ((bnd || (boot_win && state_r == S_IDLE)) && nmi_lat_r) begin
                nmi_pend_r <= 1'b1;
            end
        end
    end
    // step, then nmi, then software, then coprocessor error
    assign start = (state_r == S_IDLE) & ~bnd & (ss_pend_r | nmi_pend_r | sw_pend_r | err_pend_r);
    // events that the boundary now in hand will start
    assign evt_at_bnd = bnd & (sw_hit | nmi_lat_r | (tf_prev_r & core_in.flags[FLAG_TF]) |
                               (err_s2_r & ~ctrl_r[CTRL_BUS8]));
    assign stack_addr = 20'({ctx_ss_r, 4'h0}) + 20'(ctx_sp_r - 16'h2);

    // entry sequence: flags, cs, ip pushes, then vector reads
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r     <= S_IDLE;
            type_r      <= 8'h00;
            last_type_r <= 8'h00;
            nest_r      <= 8'h00;
            new_ip_r    <= 16'h0000;
            ctx_cs_r    <= 16'h0000;
            ctx_ip_r    <= 16'h0000;
            ctx_flags_r <= 16'h0000;
            ctx_ss_r    <= 16'h0000;
            ctx_sp_r    <= 16'h0000;
            mem_req     <= '0;
            core_out    <= '0;
        end else begin
            core_out.done <= 1'b0;
            // hold from the boundary that raises an event until all entries end
            core_out.hold <= start | boot_win | evt_at_bnd | (state_r != S_IDLE) |
                             ss_pend_r | nmi_pend_r | sw_pend_r | err_pend_r;
            unique case (state_r)
                S_IDLE: begin
                    if (bnd || (boot_win && !start)) begin
                        ctx_cs_r    <= core_in.cs;
                        ctx_ip_r    <= core_in.next_ip;
                        ctx_flags_r <= core_in.flags;
                        ctx_ss_r    <= core_in.ss;
                        ctx_sp_r    <= core_in.sp;
                    end else if (start) begin
                        if (ss_pend_r) begin
                            type_r <= T_STEP;
                        end else if (nmi_pend_r) begin
                            type_r <= T_NMI;
                            nest_r <= nest_r + 8'h1;
                        end else if (sw_pend_r) begin
                            type_r   <= sw_type_r;
                            ctx_ip_r <= sw_ip_r;
                        end else begin
                            type_r <= T_NUMERIC;
                        end
                        mem_req <= '{1'b1, 1'b1, stack_addr, ctx_flags_r};
                        ctx_sp_r <= ctx_sp_r - 16'h2;
                        state_r  <= S_PUSH_F;
                    end
                end
                S_PUSH_F: begin
                    if (mem_ack) begin
                        mem_req  <= '{1'b1, 1'b1, stack_addr, ctx_cs_r};
                        ctx_sp_r <= ctx_sp_r - 16'h2;
                        state_r  <= S_PUSH_CS;
                    end
                end
                S_PUSH_CS: begin
                    if (mem_ack) begin
                        mem_req  <= '{1'b1, 1'b1, stack_addr, ctx_ip_r};
                        ctx_sp_r <= ctx_sp_r - 16'h2;
                        state_r  <= S_PUSH_IP;
                    end
                end
                S_PUSH_IP: begin
                    if (mem_ack) begin
                        mem_req <= '{1'b1, 1'b0, {10'h000, type_r, 2'b00}, 16'h0000};
                        state_r <= S_RD_IP;
                    end
                end
                S_RD_IP: begin
                    if (mem_ack) begin
                        new_ip_r <= mem_rdata;
                        mem_req  <= '{1'b1, 1'b0, {10'h000, type_r, 2'b10}, 16'h0000};
                        state_r  <= S_RD_CS;
                    end
                end
                S_RD_CS: begin
                    if (mem_ack) begin
                        mem_req          <= '0;
                        core_out.cs      <= mem_rdata;
                        core_out.ip      <= new_ip_r;
                        core_out.flags   <= ctx_flags_r & ~((16'h1 << FLAG_IF) | (16'h1 << FLAG_TF));
                        core_out.sp      <= ctx_sp_r;
                        ctx_cs_r         <= mem_rdata;
                        ctx_ip_r         <= new_ip_r;
                        ctx_flags_r      <= ctx_flags_r & ~((16'h1 << FLAG_IF) | (16'h1 << FLAG_TF));
                        state_r          <= S_DONE;
                    end
                end
                S_DONE: begin
                    core_out.done <= 1'b1;
                    last_type_r   <= type_r;
                    state_r       <= S_IDLE;
                end
            endcase
        end
    end

    // nmi response time watch, late flag sticky, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lat_cnt_r <= 6'h00;
            late_r    <= 1'b0;
        end else begin
            if (nmi_edge && lat_cnt_r == 6'h00) begin
                lat_cnt_r <= 6'h01;
            end else if (state_r == S_DONE && type_r == T_NMI) begin
                lat_cnt_r <= 6'h00;
            end else if (lat_cnt_r != 6'h00 && lat_cnt_r != 6'h3f) begin
                lat_cnt_r <= lat_cnt_r + 6'h01;
            end
            if (lat_cnt_r > 6'(NMI_RESP_CLKS)) begin
                late_r <= 1'b1;
            end else if (wr_ok && paddr == REG_STATUS && pwdata[STAT_LATE]) begin
                late_r <= 1'b0;
            end
        end
    end

    // apb slave, no wait states, read data prepared in setup
    assign acc   = psel & penable & pready;
    assign wr_ok = acc & pwrite;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            ctrl_r  <= CTRL_RST;
        end else begin
            pready <= psel & ~penable & ~pready;
            if (psel && !penable) begin
                pslverr <= 1'b0;
                unique case (paddr)
                    REG_CTRL:   prdata <= {30'h0, ctrl_r};
                    REG_STATUS: prdata <= {21'h0, nmi_lat_r, late_r, (state_r != S_IDLE), last_type_r};
                    REG_NEST:   prdata <= {24'h0, nest_r};
                    default: begin
                        prdata  <= 32'h0000_0000;
                        pslverr <= 1'b1;
                    end
                endcase
            end
            if (wr_ok && paddr == REG_CTRL) begin
                ctrl_r <= pwdata[1:0];
            end
        end
    end

    // checks
    sequence s_flag_push;
        (state_r == S_PUSH_F) && mem_req.valid && mem_req.write;
    endsequence
    sequence s_link_push;
        (state_r == S_PUSH_CS) ##[1:8] (state_r == S_PUSH_IP);
    endsequence
    a_push_flags_first: assert property (@(posedge pclk) disable iff (!presetn) start |=> s_flag_push)
        else $error("flags not pushed first");
    a_flags_cleared: assert property (@(posedge pclk) disable iff (!presetn)
        core_out.done |-> !core_out.flags[FLAG_IF] && !core_out.flags[FLAG_TF])
        else $error("if or tf left set");
    a_cs_then_ip: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == S_PUSH_CS && mem_ack) |=> state_r == S_PUSH_IP && mem_req.wdata == ctx_ip_r)
        else $error("linkage push order wrong");
    a_vector_in_table: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == S_RD_IP && mem_req.valid) |-> mem_req.addr <= VEC_TABLE_END && mem_req.addr[1:0] == 2'b00)
        else $error("vector read outside table");
    a_nmi_latched: assert property (@(posedge pclk) disable iff (!presetn) nmi_edge |=> nmi_lat_r || nmi_pend_r)
        else $error("nmi edge lost");
    a_nmi_type_two: assert property (@(posedge pclk) disable iff (!presetn)
        (start && !ss_pend_r && nmi_pend_r) |=> type_r == T_NMI)
        else $error("nmi not type 2");
    a_ovfl_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (bnd && core_in.opcode == OP_OVFL && !core_in.flags[FLAG_OF] && !core_in.div_fault && !core_in.undef_op
         && !sw_pend_r) |=> !sw_pend_r)
        else $error("overflow trap without flag");
    a_boot_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (boot_win && nmi_lat_r && state_r == S_IDLE) |=> core_out.hold && nmi_pend_r)
        else $error("core released before boot nmi");
    a_esc_return: assert property (@(posedge pclk) disable iff (!presetn)
        (bnd && core_in.opcode[7:3] == OP_ESC_HI && sw_type == T_ESC && sw_hit
         && !core_in.div_fault && !core_in.undef_op)
        |=> sw_ip_r == ($past(core_in.seg_prefix) ? $past(core_in.start_ip) : $past(core_in.op_ip)))
        else $error("esc return address wrong");
endmodule

// [dv/ctn_partner.sv]
// partner model: nmi source, coprocessor error line, vector and stack memory
module ctn_partner
    import ctn_pkg::*;
(
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // requests from the bench
    input  wire logic         nmi_go,
    input  wire logic         err_lvl,
    // memory
    input  wire ctn_mem_req_t mem_req,
    output logic              mem_ack,
    output logic [15:0]       mem_rdata,
    // pins
    output logic              nmi_pin,
    output logic              coproc_err_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] nmi_r;
    logic [1:0] wait_r;
    assign nmi_pin = nmi_r != 2'h0;
    // nmi held two clocks, error line follows the bench
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nmi_r <= 2'h0;
            coproc_err_pin <= 1'b0;
        end else begin
            nmi_r <= nmi_go ? 2'h2 : nmi_r - {1'b0, nmi_pin};
            coproc_err_pin <= err_lvl;
        end
    end
    // entry t holds ip 10tt then cs 20tt; stale read data toggles
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack <= 1'b0;
            wait_r <= 2'h0;
            mem_rdata <= 16'h0;
        end else if (mem_ack || !mem_req.valid || wait_r != 2'h0) begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (!mem_ack && mem_req.valid) wait_r <= wait_r - 2'h1;
        end else begin
            mem_ack <= 1'b1;
            wait_r <= 2'($urandom_range(2));
            mem_rdata <= {mem_req.addr[1] ? 8'h20 : 8'h10, mem_req.addr[9:2]};
        end
    end
endmodule

// [dv/cpu_trap_and_nmi_vectoring_tb_top.sv]
// self-checking bench of the trap and nmi vectoring unit
module cpu_trap_and_nmi_vectoring_tb_top import ctn_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0]  t;
        logic [15:0] fl;
        logic [15:0] sp;
        logic        full;
    } ctn_note_t;
    logic         pclk = 1'b0;
    logic         presetn = 1'b0;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [7:0]   paddr = 8'h0;
    logic [31:0]  pwdata = 32'h0;
    logic         pready;
    logic [31:0]  prdata;
    logic         pslverr;
    ctn_core_t    c;
    ctn_entry_t   co;
    ctn_mem_req_t mreq;
    logic         mack;
    logic [15:0]  mrd;
    logic         nmi_go = 1'b0;
    logic         err_lvl = 1'b0;
    logic         nmi_pin;
    logic         cerr;
    logic         nmi_d = 1'b0;
    logic         pend_nmi = 1'b0;
    int           fails = 0;
    int           checks_done = 0;
    int           ncnt = 0;
    ctn_note_t    notes[$];
    logic [35:0]  wq[$];
    logic [31:0]  q;
    logic         e;

    always #25 pclk = ~pclk;

    ctn_trap_unit i_ctn_trap_unit (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .core_in(c), .core_out(co), .mem_req(mreq), .mem_ack(mack), .mem_rdata(mrd), .nmi_pin(nmi_pin),
        .coproc_err_pin(cerr));
    ctn_partner i_ctn_partner (.pclk(pclk), .presetn(presetn), .nmi_go(nmi_go), .err_lvl(err_lvl),
        .mem_req(mreq), .mem_ack(mack), .mem_rdata(mrd), .nmi_pin(nmi_pin), .coproc_err_pin(cerr));

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(string nm, logic [35:0] seen, logic [35:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(int n);
        if (n > 500) begin
            fails++;
            print_verdict();
        end else begin
            @(posedge pclk);
        end
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (co.hold !== 1'b0) tick(n++);
    endtask
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do tick(n++); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] x, logic xe);
        apb(1'b0, a, 32'h0);
        chk("apb read", {3'h0, e, q}, {3'h0, xe, x});
    endtask
    task automatic note_entry(ctn_core_t k, logic [7:0] t, logic [15:0] r, logic full);
        logic [19:0] b;
        b = {k.ss, 4'h0} + {4'h0, k.sp};
        notes.push_back('{t, k.flags, k.sp - 16'h6, full});
        if (full) begin
            wq.push_back({b - 20'h2, k.flags});
            wq.push_back({b - 20'h4, k.cs});
            wq.push_back({b - 20'h6, r});
        end
    endtask
    task automatic instr(logic [7:0] op, logic [7:0] imm, logic [15:0] fl, logic [1:0] flt, logic pfx,
                         int t, int rs);
        ctn_core_t   k;
        logic [15:0] r;
        k = '0;
        k.boundary = 1'b1;
        k.opcode = op;
        k.imm = imm;
        {k.div_fault, k.undef_op} = flt;
        k.seg_prefix = pfx;
        k.cs = 16'($urandom);
        k.ss = 16'($urandom);
        k.sp = 16'($urandom_range(16'hfff0, 16'h0100));
        k.start_ip = 16'($urandom_range(16'hff00));
        k.op_ip = k.start_ip + 16'h1;
        k.next_ip = k.start_ip + 16'h2;
        k.flags = fl | 16'h0200;
        k.bound_idx = {8'h0, imm};
        k.bound_lo = 16'd10;
        k.bound_hi = 16'd20;
        r = rs == 1 ? k.start_ip : rs == 2 ? k.op_ip : k.next_ip;
        wait_idle();
        if (pend_nmi) note_entry(k, T_NMI, k.next_ip, 1'b1);
        if (t >= 0) note_entry(k, 8'(t), r, !pend_nmi);
        pend_nmi = 1'b0;
        c <= k;
        @(posedge pclk);
        c.boundary <= 1'b0;
        repeat (2) @(posedge pclk);
        wait_idle();
        $display("test op %h type %0d done", op, t);
    endtask
    task automatic nmi_pulse();
        nmi_go <= 1'b1;
        @(posedge pclk);
        nmi_go <= 1'b0;
        repeat (5) @(posedge pclk);
        pend_nmi = 1'b1;
    endtask

    // compare pushes and entries with the oldest note
    always @(posedge pclk) begin : mon
        ctn_note_t n;
        ncnt <= (nmi_pin && !nmi_d) ? 0 : ncnt + 1;
        nmi_d <= nmi_pin;
        if (mreq.valid && mreq.write && mack && wq.size() > 0)
            chk("push", {mreq.addr, mreq.wdata}, wq.pop_front());
        if (co.done === 1'b1 && notes.size() == 0) chk("unexpected entry", 36'h1, 36'h0);
        else if (co.done === 1'b1) begin
            n = notes.pop_front();
            chk("vector", {4'h0, co.cs, co.ip}, {4'h0, 8'h20, n.t, 8'h10, n.t});
            if (n.full) chk("flags sp", {4'h0, co.flags, co.sp}, {4'h0, n.fl & 16'hfcff, n.sp});
            if (n.t == T_NMI) chk("nmi clocks", 36'(ncnt <= NMI_RESP_CLKS), 36'h1);
        end
    end

    // main sequence
    initial begin
        c = '0;
        c.cs = 16'hffff;
        c.sp = 16'h0800;
        void'($urandom(32'hb8253410));
        note_entry(c, T_NMI, 16'h0, 1'b1);
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        nmi_go <= 1'b1;
        @(posedge pclk);
        nmi_go <= 1'b0;
        wait_idle();
        rd(REG_CTRL, 32'h0, 1'b0);
        rd(8'h0c, 32'h0, 1'b1);
        apb(1'b1, REG_CTRL, 32'h1);
        instr(8'hf6, 8'h0, 16'h0, 2'b10, 1'b0, T_DIVIDE, 1);
        instr(OP_BREAK, 8'h0, 16'h0, 2'b00, 1'b0, T_BREAK, 0);
        instr(OP_TRAPNN, 8'h20, 16'h0, 2'b00, 1'b0, 32, 0);
        instr(OP_TRAPNN, 8'hff, 16'h0, 2'b00, 1'b0, 255, 0);
        instr(OP_OVFL, 8'h0, 16'h0800, 2'b00, 1'b0, T_OVFL, 0);
        instr(OP_OVFL, 8'h0, 16'h0, 2'b00, 1'b0, -1, 0);
        instr(OP_BOUND, 8'd25, 16'h0, 2'b00, 1'b0, T_BOUND, 1);
        instr(OP_BOUND, 8'd15, 16'h0, 2'b00, 1'b0, -1, 0);
        instr(8'h0f, 8'h0, 16'h0, 2'b01, 1'b0, T_UNDEF, 1);
        instr(8'hd9, 8'h0, 16'h0, 2'b00, 1'b1, T_ESC, 1);
        instr(8'hdc, 8'h0, 16'h0, 2'b00, 1'b0, T_ESC, 2);
        apb(1'b1, REG_CTRL, 32'h2);
        err_lvl <= 1'b1;
        repeat (4) @(posedge pclk);
        instr(8'hdf, 8'h0, 16'h0, 2'b00, 1'b0, T_ESC, 2);
        err_lvl <= 1'b0;
        apb(1'b1, REG_CTRL, 32'h0);
        instr(8'hd8, 8'h0, 16'h0, 2'b00, 1'b0, -1, 0);
        instr(8'h90, 8'h0, 16'h0100, 2'b00, 1'b0, -1, 0);
        instr(8'h90, 8'h0, 16'h0100, 2'b00, 1'b0, T_STEP, 0);
        nmi_pulse();
        instr(8'h90, 8'h0, 16'h0, 2'b00, 1'b0, -1, 0);
        nmi_pulse();
        instr(OP_BREAK, 8'h0, 16'h0, 2'b00, 1'b0, T_BREAK, 0);
        err_lvl <= 1'b1;
        repeat (4) @(posedge pclk);
        instr(8'h90, 8'h0, 16'h0, 2'b00, 1'b0, T_NUMERIC, 0);
        err_lvl <= 1'b0;
        rd(REG_NEST, 32'h3, 1'b0);
        rd(REG_STATUS, 32'h10, 1'b0);
        chk("notes left", 36'(notes.size()), 36'h0);
        print_verdict();
    end
endmodule
